// file: rtl/cbbse_exec.sv
// Bit, branch and stack instruction executor with Wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "cbbse_map.svh"

module cbbse_exec (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Wishbone slave
	input  wire cbbse_pkg::cbbse_wb_req_t wb_req,
	output var  cbbse_pkg::cbbse_wb_rsp_t wb_rsp,
	// Data memory, data back one cycle after req
	output var  cbbse_pkg::cbbse_mem_req_t mem_req,
	input  wire logic [7:0]               mem_rdata,
	// Core state
	output var  logic                     busy,
	output var  logic                     interrupt_enable_flag,
	output var  logic                     nmi_service_flag
);
	import cbbse_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [7:0] put_bit(input logic [7:0] b,
		input logic [2:0] i, input logic v);
		put_bit = b;
		put_bit[i] = v;
	endfunction

	function automatic logic in_range(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = a >= lo && a <= hi;
	endfunction

	// Cycle figure; slow selects the non-fast-RAM column
	function automatic logic [7:0] cyc_of(input cbbse_op_t o,
		input cbbse_src_t s, input logic slow);
		logic m;
		m = s == src_saddr || s == src_indirect;
		case (o)
			op_adj_add, op_adj_sub: cyc_of = 8'h04;
			op_bmov_to_c, op_band, op_bor, op_bxor:
				cyc_of = s == src_acc ? 8'h04 : (m && !slow) ? 8'h06 : 8'h07;
			op_bmov_from_c:
				cyc_of = s == src_acc ? 8'h04 : (m && !slow) ? 8'h06 : 8'h08;
			op_bset, op_bclr: begin
				if (s == src_acc)
					cyc_of = 8'h04;
				else if (s == src_stat)
					cyc_of = 8'h06;
				else if (s == src_saddr)
					cyc_of = slow ? 8'h06 : 8'h04;
				else if (s == src_indirect)
					cyc_of = slow ? 8'h08 : 8'h06;
				else
					cyc_of = 8'h08;
			end
			op_c_set, op_c_clr, op_c_inv, op_push_sw, op_pop_sw:
				cyc_of = 8'h02;
			op_call: cyc_of = 8'h07;
			op_call_fix: cyc_of = 8'h05;
			op_push_pair, op_pop_pair: cyc_of = 8'h04;
			op_stk_load: cyc_of = 8'h0A;
			op_stk_from_acc, op_acc_from_stk, op_jmp_acc: cyc_of = 8'h08;
			op_bra_bset: begin
				if (s == src_acc)
					cyc_of = 8'h08;
				else if (s == src_stat)
					cyc_of = 8'h09;
				else if (s == src_saddr)
					cyc_of = slow ? 8'h09 : 8'h08;
				else if (s == src_indirect)
					cyc_of = slow ? 8'h0B : 8'h0A;
				else
					cyc_of = 8'h0B;
			end
			op_bra_bclr:
				cyc_of = s == src_acc ? 8'h08 : (m && !slow) ? 8'h0A : 8'h0B;
			default: cyc_of = 8'h06;
		endcase
	endfunction

	function automatic logic [15:0] len_of(input cbbse_op_t o,
		input cbbse_src_t s);
		logic sh;
		sh = s == src_acc || s == src_indirect;
		case (o)
			op_bmov_to_c, op_bmov_from_c, op_band, op_bor, op_bxor:
				len_of = sh ? 16'h0002 : 16'h0003;
			op_bset, op_bclr: len_of = s == src_sfr ? 16'h0003 : 16'h0002;
			op_call, op_jmp_abs: len_of = 16'h0003;
			op_stk_load: len_of = 16'h0004;
			op_bra_bset: len_of = s == src_sfr ? 16'h0004 : 16'h0003;
			op_bra_bclr: len_of = sh ? 16'h0003 : 16'h0004;
			op_c_set, op_c_clr, op_c_inv, op_call_tbl, op_sw_break,
			op_sub_exit, op_int_exit, op_break_exit, op_push_sw,
			op_pop_sw, op_push_pair, op_pop_pair: len_of = 16'h0001;
			default: len_of = 16'h0002;
		endcase
	endfunction

	// ****************************************
	// State
	// ****************************************
	cbbse_state_t state_ff;
	cbbse_op_t    op_ff;
	cbbse_src_t   src_ff;
	logic [2:0]   bit_ff;
	logic [15:0]  opnd_ff, prog_ctr_ff, stk_ptr_ff, acc_pair_ff, reg_pair_ff;
	logic [7:0]   disp_ff, stat_word_ff, wait_cfg_ff;
	logic [7:0]   cnt_ff, total_ff, last_cyc_ff;
	logic         nmi_ff, ack_ff, rd_pend_ff;
	logic [1:0]   rd_idx_ff;
	logic [7:0]   rb_ff [3];
	logic [31:0]  rdat_ff;

	logic [15:0] nxt_prog_ctr, nxt_stk_ptr, nxt_acc_pair, nxt_reg_pair;
	logic [7:0]  nxt_stat_word;
	logic        nxt_nmi;

	logic        bus_hit, bus_wr, idle, run, last, start, sbit, cv;
	logic [15:0] len, next_addr, target, rbase, waddr;
	logic [7:0]  n_wr, n_rd, w0, w1, w2, wsel, acc, rbv [3];
	logic        rd_first, do_wr, do_rd;
	logic [7:0]  wstep, rstep, adj, da;
	logic        lo_fix, hi_fix;

	assign bus_hit = wb_req.cyc && wb_req.stb && !ack_ff;
	assign bus_wr  = bus_hit && wb_req.we;
	assign idle    = state_ff == st_idle;
	assign run     = state_ff == st_run;
	assign last    = run && cnt_ff == total_ff - 8'h01;
	// Writes while busy are dropped so a running op sees stable inputs
	assign start   = bus_wr && idle && wb_req.adr == `CBBSE_OFF_CMD
		&& wb_req.sel[0];
	assign acc     = acc_pair_ff[15:8];
	assign len     = len_of(op_ff, src_ff);
	assign next_addr = prog_ctr_ff + len;
	assign target  = next_addr + {{8{disp_ff[7]}}, disp_ff};
	assign cv      = stat_word_ff[`CBBSE_SW_CARRY];

	assign busy = run;
	assign interrupt_enable_flag = stat_word_ff[`CBBSE_SW_INTEN];
	assign nmi_service_flag = nmi_ff;
	assign wb_rsp = '{ack: ack_ff, dat: rdat_ff};

	// Freshest read byte: the one in flight wins over the stored copy
	always_comb begin
		for (int i = 0; i < 3; i++)
			rbv[i] = (rd_pend_ff && rd_idx_ff == 2'(i)) ? mem_rdata : rb_ff[i];
	end

	always_comb begin
		case (src_ff)
			src_acc:  sbit = acc[bit_ff];
			src_stat: sbit = stat_word_ff[bit_ff];
			default:  sbit = rbv[0][bit_ff];
		endcase
	end

	// ****************************************
	// Memory access plan
	// ****************************************
	always_comb begin
		n_wr = 8'h00;
		n_rd = 8'h00;
		rd_first = 1'b0;
		w0 = 8'h00;
		w1 = 8'h00;
		w2 = 8'h00;
		rbase = stk_ptr_ff;
		case (op_ff)
			op_call, op_call_fix, op_call_tbl: begin
				n_wr = 8'h02;
				w0 = next_addr[15:8];
				w1 = next_addr[7:0];
				if (op_ff == op_call_tbl) begin
					n_rd = 8'h02;
					rbase = {`CBBSE_TBL_PAGE, opnd_ff[7:0]};
				end
			end
			op_sw_break: begin
				n_wr = 8'h03;
				n_rd = 8'h02;
				w0 = stat_word_ff;
				w1 = next_addr[15:8];
				w2 = next_addr[7:0];
				rbase = `CBBSE_BREAK_VEC;
			end
			op_sub_exit, op_pop_pair: n_rd = 8'h02;
			op_int_exit, op_break_exit: n_rd = 8'h03;
			op_pop_sw: n_rd = 8'h01;
			op_push_sw: begin
				n_wr = 8'h01;
				w0 = stat_word_ff;
			end
			op_push_pair: begin
				n_wr = 8'h02;
				w0 = reg_pair_ff[15:8];
				w1 = reg_pair_ff[7:0];
			end
			op_bmov_to_c, op_band, op_bor, op_bxor, op_bra_bset,
			op_bra_bclr: begin
				n_rd = {7'h00, src_ff > src_stat};
				rbase = opnd_ff;
			end
			op_bmov_from_c, op_bset, op_bclr: begin
				// Read-modify-write keeps the other seven bits
				rd_first = 1'b1;
				n_rd = {7'h00, src_ff > src_stat};
				n_wr = n_rd;
				rbase = opnd_ff;
				w0 = put_bit(rbv[0], bit_ff, op_ff == op_bset
					|| (op_ff == op_bmov_from_c && cv));
			end
			default: ;
		endcase
	end

	always_comb begin
		wstep = rd_first ? cnt_ff - n_rd : cnt_ff;
		rstep = rd_first ? cnt_ff : cnt_ff - n_wr;
		do_wr = run && (rd_first ? (cnt_ff >= n_rd && cnt_ff < n_rd + n_wr)
			: cnt_ff < n_wr);
		do_rd = run && (rd_first ? cnt_ff < n_rd
			: (cnt_ff >= n_wr && cnt_ff < n_wr + n_rd));
		waddr = rd_first ? opnd_ff : stk_ptr_ff - 16'h0001 - {8'h00, wstep};
		wsel = wstep == 8'h00 ? w0 : wstep == 8'h01 ? w1 : w2;
		mem_req.req = do_wr || do_rd;
		mem_req.we = do_wr;
		mem_req.addr = do_wr ? waddr : rbase + {8'h00, rstep};
		mem_req.wdata = do_wr ? wsel : 8'h00;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= st_idle;
			cnt_ff <= 8'h00;
			total_ff <= 8'h01;
			last_cyc_ff <= 8'h00;
		end else if (start) begin
			state_ff <= st_run;
			cnt_ff <= 8'h00;
			total_ff <= cyc_of(cbbse_op_t'(wb_req.dat[5:0]),
				cbbse_src_t'(wb_req.dat[10:8]),
				!in_range(opnd_ff, `CBBSE_FAST_LO, `CBBSE_FAST_HI));
		end else if (run) begin
			cnt_ff <= cnt_ff + 8'h01;
			if (mem_req.req
				&& in_range(mem_req.addr, `CBBSE_EXT_LO, `CBBSE_EXT_HI))
				total_ff <= total_ff + (do_wr ? {4'h0, wait_cfg_ff[7:4]}
					: {4'h0, wait_cfg_ff[3:0]});
			if (last) begin
				state_ff <= st_idle;
				last_cyc_ff <= cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_ff <= 1'b0;
			rd_idx_ff <= 2'h0;
			for (int i = 0; i < 3; i++)
				rb_ff[i] <= 8'h00;
		end else begin
			rd_pend_ff <= do_rd;
			rd_idx_ff <= rstep[1:0];
			if (rd_pend_ff)
				rb_ff[rd_idx_ff] <= mem_rdata;
		end
	end

	// ****************************************
	// Results at the last cycle
	// ****************************************
	always_comb begin
		nxt_prog_ctr = prog_ctr_ff;
		nxt_stk_ptr = stk_ptr_ff;
		nxt_acc_pair = acc_pair_ff;
		nxt_reg_pair = reg_pair_ff;
		nxt_stat_word = stat_word_ff;
		nxt_nmi = nmi_ff;
		lo_fix = 1'b0;
		hi_fix = 1'b0;
		adj = 8'h00;
		da = 8'h00;
		if (last) begin
			nxt_prog_ctr = next_addr;
			case (op_ff)
				op_adj_add, op_adj_sub: begin
					lo_fix = stat_word_ff[`CBBSE_SW_AUXC]
						|| (op_ff == op_adj_add && acc[3:0] > 4'h9);
					hi_fix = cv || (op_ff == op_adj_add && acc > 8'h99);
					adj = {hi_fix ? 4'h6 : 4'h0, lo_fix ? 4'h6 : 4'h0};
					da = op_ff == op_adj_add ? acc + adj : acc - adj;
					nxt_acc_pair[15:8] = da;
					nxt_stat_word[`CBBSE_SW_ZERO] = da == 8'h00;
					nxt_stat_word[`CBBSE_SW_AUXC] = op_ff == op_adj_add
						? (acc[3:0] > 4'hF - adj[3:0])
						: (acc[3:0] < adj[3:0]);
					nxt_stat_word[`CBBSE_SW_CARRY] = hi_fix;
				end
				op_bmov_to_c: nxt_stat_word[`CBBSE_SW_CARRY] = sbit;
				op_band: nxt_stat_word[`CBBSE_SW_CARRY] = cv & sbit;
				op_bor: nxt_stat_word[`CBBSE_SW_CARRY] = cv | sbit;
				op_bxor: nxt_stat_word[`CBBSE_SW_CARRY] = cv ^ sbit;
				op_bmov_from_c, op_bset, op_bclr: begin
					if (src_ff == src_acc)
						nxt_acc_pair[15:8] = put_bit(acc, bit_ff,
							op_ff == op_bset || (op_ff == op_bmov_from_c && cv));
					else if (src_ff == src_stat)
						nxt_stat_word = put_bit(stat_word_ff, bit_ff,
							op_ff == op_bset
							|| (op_ff == op_bmov_from_c && cv));
				end
				op_c_set: nxt_stat_word[`CBBSE_SW_CARRY] = 1'b1;
				op_c_clr: nxt_stat_word[`CBBSE_SW_CARRY] = 1'b0;
				op_c_inv: nxt_stat_word[`CBBSE_SW_CARRY] = !cv;
				op_call, op_call_fix, op_call_tbl: begin
					nxt_stk_ptr = stk_ptr_ff - 16'h0002;
					if (op_ff == op_call)
						nxt_prog_ctr = opnd_ff;
					else if (op_ff == op_call_fix)
						nxt_prog_ctr = {`CBBSE_FIX_AREA, opnd_ff[10:0]};
					else
						nxt_prog_ctr = {rbv[1], rbv[0]};
				end
				op_sw_break: begin
					nxt_stk_ptr = stk_ptr_ff - 16'h0003;
					nxt_prog_ctr = {rbv[1], rbv[0]};
					nxt_stat_word[`CBBSE_SW_INTEN] = 1'b0;
				end
				op_sub_exit: begin
					nxt_prog_ctr = {rbv[1], rbv[0]};
					nxt_stk_ptr = stk_ptr_ff + 16'h0002;
				end
				op_int_exit, op_break_exit: begin
					nxt_prog_ctr = {rbv[1], rbv[0]};
					nxt_stat_word = rbv[2];
					nxt_stk_ptr = stk_ptr_ff + 16'h0003;
					if (op_ff == op_int_exit)
						nxt_nmi = 1'b0;
				end
				op_push_sw: nxt_stk_ptr = stk_ptr_ff - 16'h0001;
				op_pop_sw: begin
					nxt_stat_word = rbv[0];
					nxt_stk_ptr = stk_ptr_ff + 16'h0001;
				end
				op_push_pair: nxt_stk_ptr = stk_ptr_ff - 16'h0002;
				op_pop_pair: begin
					nxt_reg_pair = {rbv[1], rbv[0]};
					nxt_stk_ptr = stk_ptr_ff + 16'h0002;
				end
				op_stk_load: nxt_stk_ptr = opnd_ff;
				op_stk_from_acc: nxt_stk_ptr = acc_pair_ff;
				op_acc_from_stk: nxt_acc_pair = stk_ptr_ff;
				op_jmp_abs: nxt_prog_ctr = opnd_ff;
				op_jmp_rel: nxt_prog_ctr = target;
				op_jmp_acc: nxt_prog_ctr = acc_pair_ff;
				op_bra_c, op_bra_nc, op_bra_z, op_bra_nz: begin
					if ((op_ff == op_bra_c && cv)
						|| (op_ff == op_bra_nc && !cv)
						|| (op_ff == op_bra_z && stat_word_ff[`CBBSE_SW_ZERO])
						|| (op_ff == op_bra_nz
						&& !stat_word_ff[`CBBSE_SW_ZERO]))
						nxt_prog_ctr = target;
				end
				op_bra_bset, op_bra_bclr: begin
					if (sbit == (op_ff == op_bra_bset))
						nxt_prog_ctr = target;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_ff <= op_adj_add;
			src_ff <= src_acc;
			bit_ff <= 3'h0;
		end else if (start) begin
			op_ff <= cbbse_op_t'(wb_req.dat[5:0]);
			src_ff <= cbbse_src_t'(wb_req.dat[10:8]);
			bit_ff <= wb_req.dat[14:12];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			opnd_ff <= 16'h0000;
			disp_ff <= 8'h00;
			wait_cfg_ff <= `CBBSE_RST_WAIT;
		end else if (bus_wr && idle) begin
			if (wb_req.adr == `CBBSE_OFF_OPND)
				opnd_ff <= merge16(opnd_ff, wb_req.dat, wb_req.sel);
			if (wb_req.adr == `CBBSE_OFF_DISP && wb_req.sel[0])
				disp_ff <= wb_req.dat[7:0];
			if (wb_req.adr == `CBBSE_OFF_WAIT && wb_req.sel[0])
				wait_cfg_ff <= wb_req.dat[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prog_ctr_ff <= 16'h0000;
			stk_ptr_ff <= `CBBSE_RST_STACK;
			acc_pair_ff <= 16'h0000;
			reg_pair_ff <= 16'h0000;
			stat_word_ff <= `CBBSE_RST_STAT;
			nmi_ff <= 1'b0;
		end else if (bus_wr && idle) begin
			case (wb_req.adr)
				`CBBSE_OFF_PROG:
					prog_ctr_ff <= merge16(prog_ctr_ff, wb_req.dat, wb_req.sel);
				`CBBSE_OFF_STACK:
					stk_ptr_ff <= merge16(stk_ptr_ff, wb_req.dat, wb_req.sel);
				`CBBSE_OFF_ACC:
					acc_pair_ff <= merge16(acc_pair_ff, wb_req.dat, wb_req.sel);
				`CBBSE_OFF_PAIR:
					reg_pair_ff <= merge16(reg_pair_ff, wb_req.dat, wb_req.sel);
				`CBBSE_OFF_STAT:
					if (wb_req.sel[0])
						stat_word_ff <= wb_req.dat[7:0];
				`CBBSE_OFF_NMI:
					if (wb_req.sel[0])
						nmi_ff <= wb_req.dat[0];
				default: ;
			endcase
		end else begin
			prog_ctr_ff <= nxt_prog_ctr;
			stk_ptr_ff <= nxt_stk_ptr;
			acc_pair_ff <= nxt_acc_pair;
			reg_pair_ff <= nxt_reg_pair;
			stat_word_ff <= nxt_stat_word;
			nmi_ff <= nxt_nmi;
		end
	end

	// ****************************************
	// Wishbone answer, one cycle after strobe
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_hit;
			if (bus_hit && !wb_req.we) begin
				case (wb_req.adr)
					`CBBSE_OFF_CMD:
						rdat_ff <= {17'h0, bit_ff, 1'b0, src_ff, 2'h0, op_ff};
					`CBBSE_OFF_OPND:   rdat_ff <= {16'h0, opnd_ff};
					`CBBSE_OFF_DISP:   rdat_ff <= {24'h0, disp_ff};
					`CBBSE_OFF_PROG:   rdat_ff <= {16'h0, prog_ctr_ff};
					`CBBSE_OFF_STACK:  rdat_ff <= {16'h0, stk_ptr_ff};
					`CBBSE_OFF_ACC:    rdat_ff <= {16'h0, acc_pair_ff};
					`CBBSE_OFF_STAT:   rdat_ff <= {24'h0, stat_word_ff};
					`CBBSE_OFF_PAIR:   rdat_ff <= {16'h0, reg_pair_ff};
					`CBBSE_OFF_STATUS: rdat_ff <= {16'h0, last_cyc_ff, 7'h0, run};
					`CBBSE_OFF_NMI:    rdat_ff <= {31'h0, nmi_ff};
					`CBBSE_OFF_WAIT:   rdat_ff <= {24'h0, wait_cfg_ff};
					default:           rdat_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/cbbse_map.svh
// Offsets, field positions, reset values and fixed addresses of the executor
`ifndef CBBSE_MAP_SVH
`define CBBSE_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CBBSE_OFF_CMD    8'h00
`define CBBSE_OFF_OPND   8'h04
`define CBBSE_OFF_DISP   8'h08
`define CBBSE_OFF_PROG   8'h0C
`define CBBSE_OFF_STACK  8'h10
`define CBBSE_OFF_ACC    8'h14
`define CBBSE_OFF_STAT   8'h18
`define CBBSE_OFF_PAIR   8'h1C
`define CBBSE_OFF_STATUS 8'h20
`define CBBSE_OFF_NMI    8'h24
`define CBBSE_OFF_WAIT   8'h28

// ****************************************
// Status word bits and fixed patterns
// ****************************************
`define CBBSE_SW_CARRY   0
`define CBBSE_SW_AUXC    4
`define CBBSE_SW_ZERO    6
`define CBBSE_SW_INTEN   7
`define CBBSE_FIX_AREA   5'h01
`define CBBSE_TBL_PAGE   8'h00
`define CBBSE_BREAK_VEC  16'h003E
`define CBBSE_RST_STAT   8'h00
`define CBBSE_RST_STACK  16'h0000
`define CBBSE_RST_WAIT   8'h00

// ****************************************
// Memory areas
// ****************************************
`define CBBSE_FAST_LO    16'hFB00
`define CBBSE_FAST_HI    16'hFEFF
`define CBBSE_EXT_LO     16'h8000
`define CBBSE_EXT_HI     16'hEFFF

`endif

// file: rtl/cbbse_pkg.sv
// Types shared by the executor and its bench
package cbbse_pkg;

	typedef enum logic [5:0] {
		op_adj_add, op_adj_sub, op_bmov_to_c, op_bmov_from_c,
		op_band, op_bor, op_bxor, op_bset, op_bclr,
		op_c_set, op_c_clr, op_c_inv, op_call, op_call_fix,
		op_call_tbl, op_sw_break, op_sub_exit, op_int_exit,
		op_break_exit, op_push_sw, op_pop_sw, op_push_pair,
		op_pop_pair, op_stk_load, op_stk_from_acc, op_acc_from_stk,
		op_jmp_abs, op_jmp_rel, op_jmp_acc, op_bra_c, op_bra_nc,
		op_bra_z, op_bra_nz, op_bra_bset, op_bra_bclr
	} cbbse_op_t;

	typedef enum logic [2:0] {
		src_acc, src_stat, src_saddr, src_sfr, src_indirect
	} cbbse_src_t;

	typedef enum logic {st_idle, st_run} cbbse_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} cbbse_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} cbbse_wb_rsp_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cbbse_mem_req_t;

endpackage

// file: verification/cbbse_exec_props.sv
// Port assertions for the executor
`timescale 1ns/1ns
`default_nettype none
module cbbse_exec_props (
	// Clock and reset
	input wire logic                      mclk,
	input wire logic                      rst_n,
	// Register bus
	input wire cbbse_pkg::cbbse_wb_req_t  wb_req,
	input wire cbbse_pkg::cbbse_wb_rsp_t  wb_rsp,
	// Memory port
	input wire cbbse_pkg::cbbse_mem_req_t mem_req,
	input wire logic [7:0]                mem_rdata,
	// Core state
	input wire logic                      busy,
	input wire logic                      interrupt_enable_flag,
	input wire logic                      nmi_service_flag
);
	import cbbse_pkg::*;
	logic [10:0] cmd_ff;
	logic        fast;
	// Stack in top page, so no write waits stretch the count
	assign fast = mem_req.addr >= 16'hF000;
	// Writes while busy are dropped, so latch only when idle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cmd_ff <= '0;
		else if (wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0]
			&& wb_req.adr == 8'h00 && !wb_rsp.ack && !busy)
			cmd_ff <= wb_req.dat[10:0];
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_cflag;
		$rose(busy) && cmd_ff[5:0] inside {op_c_set, op_c_clr, op_c_inv}
		|-> busy[*2] ##1 !busy;
	endproperty
	a_cflag: assert property (p_cflag) else $error("carry op length");
	property p_push_sw;
		$rose(busy) && cmd_ff[5:0] == op_push_sw && fast
		|-> mem_req.req && mem_req.we ##1 busy && !mem_req.req ##1 !busy;
	endproperty
	a_push_sw: assert property (p_push_sw) else $error("status push");
	property p_call;
		$rose(busy) && cmd_ff[5:0] == op_call && fast |-> busy[*7] ##1 !busy;
	endproperty
	a_call: assert property (p_call) else $error("call length");
	property p_ret;
		$rose(busy) && cmd_ff[5:0] == op_sub_exit && fast
		|-> busy[*6] ##1 !busy;
	endproperty
	a_ret: assert property (p_ret) else $error("return length");
	property p_band;
		$rose(busy) && cmd_ff[5:0] == op_band && cmd_ff[10:8] == 3'h0
		|-> (busy && !mem_req.req)[*4] ##1 !busy;
	endproperty
	a_band: assert property (p_band) else $error("bit and on A");
	property p_brk;
		$fell(busy) && cmd_ff[5:0] == op_sw_break |-> !interrupt_enable_flag;
	endproperty
	a_brk: assert property (p_brk) else $error("break left IE set");
	property p_interrupt_exit;
		$fell(busy) && cmd_ff[5:0] == op_int_exit |-> !nmi_service_flag;
	endproperty
	a_interrupt_exit: assert property (p_interrupt_exit) else $error("NMI flag kept");
	property p_break_exit;
		$fell(busy) && cmd_ff[5:0] == op_break_exit
		|-> $stable(nmi_service_flag);
	endproperty
	a_break_exit: assert property (p_break_exit) else $error("NMI flag moved");
	c_call: cover property ($rose(busy) && cmd_ff[5:0] == op_call);
	c_brk: cover property ($fell(busy) && cmd_ff[5:0] == op_sw_break);
	c_read: cover property (busy && mem_req.req && !mem_req.we);
endmodule
`default_nettype wire

// file: verification/cbbse_exec_tb.sv
// Self-checking bench for the executor
`timescale 1ns/1ns
`default_nettype none
module cbbse_exec_tb;
	import cbbse_pkg::*;
	logic           mclk = 1'b0;
	logic           rst_n = 1'b0;
	cbbse_wb_req_t  wb_req = '0;
	cbbse_wb_rsp_t  wb_rsp;
	cbbse_mem_req_t mem_req;
	logic [7:0]     mem_rdata, d;
	logic           busy, ie, nmi, c, tk, rd_pend = 1'b0;
	logic [31:0]    exp_q[$];
	logic [31:0]    seed = 32'h52AF11ED;
	logic [15:0]    v;
	int             num_errors = 0, n_checks = 0, tmo = 0;
	cbbse_op_t      br[4] = '{op_bra_c, op_bra_nc, op_bra_z, op_bra_nz};
	cbbse_op_t      bo[4] = '{op_band, op_bor, op_bxor, op_bmov_to_c};
	cbbse_op_t      co[3] = '{op_c_set, op_c_clr, op_c_inv};
	always #10 mclk = ~mclk;
	cbbse_exec u_cbbse_exec (.mclk(mclk), .rst_n(rst_n), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.busy(busy), .interrupt_enable_flag(ie), .nmi_service_flag(nmi));
	cbbse_mem_model u_cbbse_mem_model (.mclk(mclk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hold the request until ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
		wb_req <= '{1'b1, 1'b1, w, a, 4'hF, x};
		rd_pend <= !w;
		do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
		wb_req <= '0;
		rd_pend <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] x);
		wb(1'b1, a, {16'h0, x});
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back({16'h0, e});
		wb(1'b0, a, '0);
	endtask
	// Busy is read on falling edges, where it has settled
	task automatic run(input cbbse_op_t o, input logic [2:0] s,
		input logic [2:0] b, input logic [7:0] n);
		wr(8'h00, {1'b0, b, 1'b0, s, 2'b0, 6'(o)});
		@(negedge mclk);
		while (busy === 1'b1) @(negedge mclk);
		@(posedge mclk);
		rd(8'h20, {n, 8'h00});
	endtask
	always @(posedge mclk)
		if (wb_rsp.ack === 1'b1 && rd_pend)
			chk(wb_rsp.dat, exp_q.pop_front());
	always @(posedge mclk) begin
		tmo++;
		if (tmo == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		wr(8'h10, 16'hFE00);
		wr(8'h18, 16'h0051);
		run(op_push_sw, 3'h0, 3'h0, 8'h02);
		rd(8'h10, 16'hFDFF);
		wr(8'h18, 16'h0000);
		run(op_pop_sw, 3'h0, 3'h0, 8'h02);
		rd(8'h18, 16'h0051);
		seed = lfsr(seed);
		v = seed[15:0];
		wr(8'h1C, v);
		run(op_push_pair, 3'h0, 3'h0, 8'h04);
		wr(8'h1C, ~v);
		run(op_pop_pair, 3'h0, 3'h0, 8'h04);
		rd(8'h1C, v);
		rd(8'h10, 16'hFE00);
		$display("stack test done");
		wr(8'h0C, 16'h1234);
		wr(8'h04, 16'hC35A);
		run(op_call, 3'h0, 3'h0, 8'h07);
		rd(8'h0C, 16'hC35A);
		rd(8'h10, 16'hFDFE);
		run(op_sub_exit, 3'h0, 3'h0, 8'h06);
		rd(8'h0C, 16'h1237);
		wr(8'h04, 16'h05A5);
		run(op_call_fix, 3'h0, 3'h0, 8'h05);
		rd(8'h0C, 16'h0DA5);
		run(op_sub_exit, 3'h0, 3'h0, 8'h06);
		rd(8'h0C, 16'h1239);
		u_cbbse_mem_model.mem[16'h0040] = 8'h78;
		u_cbbse_mem_model.mem[16'h0041] = 8'h56;
		wr(8'h04, 16'h0040);
		run(op_call_tbl, 3'h0, 3'h0, 8'h06);
		rd(8'h0C, 16'h5678);
		run(op_sub_exit, 3'h0, 3'h0, 8'h06);
		u_cbbse_mem_model.mem[16'h003E] = 8'hEF;
		u_cbbse_mem_model.mem[16'h003F] = 8'hBE;
		for (int i = 0; i < 2; i++) begin
			wr(8'h24, 16'h0001);
			wr(8'h18, 16'h0080);
			run(op_sw_break, 3'h0, 3'h0, 8'h06);
			rd(8'h0C, 16'hBEEF);
			rd(8'h18, 16'h0000);
			run(i ? op_int_exit : op_break_exit, 3'h0, 3'h0, 8'h06);
			rd(8'h18, 16'h0080);
			rd(8'h0C, 16'h123B + 16'(i));
			rd(8'h24, {15'h0, i == 0});
		end
		$display("call test done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			c = i[0];
			tk = c ^ i[1];
			wr(8'h0C, seed[31:16]);
			wr(8'h08, {8'h00, d});
			wr(8'h18, {9'h0, c, 5'h0, c});
			run(br[i[2:1]], 3'h0, 3'h0, 8'h06);
			rd(8'h0C, seed[31:16] + 16'h2 + (tk ? {{8{d[7]}}, d} : 16'h0));
		end
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			c = i[2];
			tk = seed[24 + seed[2:0]];
			d = {4'h0, tk, c ^ tk, c | tk, c & tk};
			wr(8'h14, seed[31:16]);
			wr(8'h18, {15'h0, c});
			run(bo[i[1:0]], 3'h0, seed[2:0], 8'h04);
			rd(8'h18, {15'h0, d[i[1:0]]});
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'h18, 16'h0001);
			run(co[i], 3'h0, 3'h0, 8'h02);
			rd(8'h18, {15'h0, i == 0});
		end
		wr(8'h18, 16'h0000);
		run(op_bset, 3'h1, 3'h6, 8'h06);
		rd(8'h18, 16'h0040);
		wr(8'h18, 16'h0000);
		wr(8'h14, 16'h3C00);
		run(op_adj_add, 3'h0, 3'h0, 8'h04);
		rd(8'h14, 16'h4200);
		rd(8'h18, 16'h0010);
		wr(8'h14, 16'h2D00);
		run(op_adj_sub, 3'h0, 3'h0, 8'h04);
		rd(8'h14, 16'h2700);
		rd(8'h18, 16'h0000);
		u_cbbse_mem_model.mem[16'hFC00] = 8'h02;
		wr(8'h0C, 16'h1000);
		wr(8'h08, 16'h0010);
		wr(8'h04, 16'hFC00);
		run(op_bra_bset, 3'h4, 3'h1, 8'h0A);
		rd(8'h0C, 16'h1013);
		run(op_bra_bclr, 3'h4, 3'h1, 8'h0A);
		rd(8'h0C, 16'h1016);
		$display("adjust and bit branch test done");
		wr(8'h14, 16'hABCD);
		run(op_jmp_acc, 3'h0, 3'h0, 8'h08);
		rd(8'h0C, 16'hABCD);
		u_cbbse_mem_model.mem[16'h9000] = 8'h20;
		wr(8'h28, 16'h0003);
		wr(8'h04, 16'h9000);
		wr(8'h18, 16'h0000);
		run(op_bmov_to_c, 3'h4, 3'h5, 8'h0A);
		rd(8'h18, 16'h0001);
		rd(8'h3C, 16'h0000);
		rd(8'h00, {1'b0, 3'h5, 1'b0, 3'h4, 2'b0, 6'(op_bmov_to_c)});
		$display("bit test done");
		report_and_stop();
	end
endmodule
bind cbbse_exec cbbse_exec_props u_cbbse_exec_props (.mclk(mclk),
	.rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .mem_req(mem_req),
	.mem_rdata(mem_rdata), .busy(busy),
	.interrupt_enable_flag(interrupt_enable_flag),
	.nmi_service_flag(nmi_service_flag));
`default_nettype wire

// file: verification/cbbse_mem_model.sv
// Data memory model on the executor's memory port
`timescale 1ns/1ns
`default_nettype none
module cbbse_mem_model (
	// Clock
	input  wire logic                      mclk,
	// Access from the executor
	input  wire cbbse_pkg::cbbse_mem_req_t mem_req,
	output var  logic [7:0]                mem_rdata
);
	import cbbse_pkg::*;
	logic [7:0] mem [0:65535];
	// Data valid only one cycle after a read; toggles otherwise
	always @(posedge mclk) begin
		if (mem_req.req && mem_req.we)
			mem[mem_req.addr] <= mem_req.wdata;
		if (mem_req.req && !mem_req.we)
			mem_rdata <= mem[mem_req.addr];
		else
			mem_rdata <= ~mem_rdata;
	end
	initial mem_rdata = 8'h5A;
endmodule
`default_nettype wire
